/* design/adc_gain_pin_select_regs.sv */
// Register bank: blue gain, fine top references, pin and clock control,
// and the gated calibration registers.
// Assumes the serial front end deserialises MSB first and presents
// whole bytes with one-cycle write and read strobes on sys_clk_i.
`default_nettype none
module adc_gain_pin_select_regs
	import gain_regs_pkg::*;
(
	input wire logic sys_clk_i, // 20 MHz clock
	input wire logic rst_b_i, // Synchronous reset, low
	input wire logic [7:0] addr_i, // Register offset
	input wire logic [7:0] wdata_i, // Write byte, MSB is bit 7
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	input wire logic test_pin_i, // Test mode strap pin
	input wire logic readback_clock_i, // Raw readback clock
	output logic [7:0] rdata_o, // Read byte, registered
	output logic [1:0] blue_gain_code_o, // Blue gain 1.0..1.6
	output logic [7:0] red_top_ref_code_o, // Red top reference
	output logic [7:0] green_top_ref_code_o, // Green top reference
	output logic [7:0] blue_top_ref_code_o, // Blue top reference
	output logic [1:0] readback_clock_delay_o, // Delay in 0.5 ns steps
	output logic readback_clock_o, // Readback clock out
	output logic gp_out_one_o, // General pin one
	output logic gp_out_two_o, // General pin two
	output logic gp_out_three_o, // General pin three
	output logic [8*CAL_COUNT-1:0] cal_bytes_o // Calibration contents
);
	logic [7:0] blue_coarse_q, blue_coarse_d;
	logic [7:0] red_fine_q, red_fine_d;
	logic [7:0] green_fine_q, green_fine_d;
	logic [7:0] blue_fine_q, blue_fine_d;
	logic [7:0] pin_ctrl_q, pin_ctrl_d;
	logic [7:0] cal_q [CAL_COUNT];
	logic [7:0] cal_d [CAL_COUNT];
	logic [7:0] rdata_q, rdata_d;
	logic test_s1_q, test_s2_q;
	logic in_cal, cal_open;
	logic [2:0] cal_idx;

	//----------------------------------------
	// Elaboration checks
	//----------------------------------------
	// The three-bit index must cover the window exactly,
	// or a calibration write would land in the wrong byte
	localparam int CAL_SPAN = int'(OFF_CAL_LAST) - int'(OFF_CAL_FIRST) + 1;
	generate
		if ((CAL_COUNT != CAL_SPAN) || (CAL_COUNT > 8)) begin : g_bad_cal
			$error("Calibration count does not fit its window");
		end
	endgenerate

	//----------------------------------------
	// Offset decode
	//----------------------------------------
	// Shared by the write and read paths, so that the two
	// can never disagree about which register an offset names
	typedef enum logic [2:0] {
		SEL_BLUE_COARSE,
		SEL_RED_FINE,
		SEL_GREEN_FINE,
		SEL_BLUE_FINE,
		SEL_PIN_CTRL,
		SEL_OTHER
	} reg_sel_e;

	function automatic reg_sel_e decode_sel(input logic [7:0] off);
		reg_sel_e sel_v;
		case (off)
			OFF_BLUE_COARSE: sel_v = SEL_BLUE_COARSE;
			OFF_RED_FINE: sel_v = SEL_RED_FINE;
			OFF_GREEN_FINE: sel_v = SEL_GREEN_FINE;
			OFF_BLUE_FINE: sel_v = SEL_BLUE_FINE;
			OFF_PIN_CTRL: sel_v = SEL_PIN_CTRL;
			default: sel_v = SEL_OTHER;
		endcase
		return sel_v;
	endfunction

	reg_sel_e sel;

	//----------------------------------------
	// Test strap synchroniser
	//----------------------------------------
	// Strap comes from a pin, so two flops before use
	// A strap change therefore takes two edges to reach the gate
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			test_s1_q <= 1'b0;
			test_s2_q <= 1'b0;
		end else begin
			test_s1_q <= test_pin_i;
			test_s2_q <= test_s1_q;
		end
	end

	cal_gate u_gate (
		.addr_i(addr_i),
		.cal_access_i(pin_ctrl_q[POS_CAL_ACCESS]),
		.test_mode_i(test_s2_q),
		.in_cal_o(in_cal),
		.cal_open_o(cal_open)
	);

	// Index is only meaningful inside the calibration window
	assign cal_idx = 3'(addr_i - OFF_CAL_FIRST);
	// Decoded once, used by both write and read paths
	assign sel = decode_sel(addr_i);

	//----------------------------------------
	// Write decode
	//----------------------------------------
	// Reserved bits stored as written; the host keeps them legal
	always_comb begin
		blue_coarse_d = blue_coarse_q;
		red_fine_d = red_fine_q;
		green_fine_d = green_fine_q;
		blue_fine_d = blue_fine_q;
		pin_ctrl_d = pin_ctrl_q;
		for (int i = 0; i < CAL_COUNT; i++) begin
			cal_d[i] = cal_q[i];
		end
		if (wr_i) begin
			case (sel)
				SEL_BLUE_COARSE: blue_coarse_d = wdata_i;
				SEL_RED_FINE: red_fine_d = wdata_i;
				SEL_GREEN_FINE: green_fine_d = wdata_i;
				SEL_BLUE_FINE: blue_fine_d = wdata_i;
				SEL_PIN_CTRL: pin_ctrl_d = wdata_i;
				default: begin
					// Blocked calibration writes just vanish
					if (in_cal && cal_open) begin
						cal_d[cal_idx] = wdata_i;
					end
				end
			endcase
		end
	end

	//----------------------------------------
	// Read mux
	//----------------------------------------
	// Unmapped offsets read as zero
	// A read beside a write in one cycle returns the old byte
	always_comb begin
		rdata_d = rdata_q;
		if (rd_i) begin
			case (sel)
				SEL_BLUE_COARSE: rdata_d = blue_coarse_q;
				SEL_RED_FINE: rdata_d = red_fine_q;
				SEL_GREEN_FINE: rdata_d = green_fine_q;
				SEL_BLUE_FINE: rdata_d = blue_fine_q;
				SEL_PIN_CTRL: rdata_d = pin_ctrl_q;
				default: begin
					if (in_cal && cal_open) begin
						rdata_d = cal_q[cal_idx];
					end else begin
						rdata_d = 8'h00;
					end
				end
			endcase
		end
	end

	//----------------------------------------
	// Register state
	//----------------------------------------
	// All bank registers share one synchronous reset
	always_ff @(posedge sys_clk_i) begin
		if (!rst_b_i) begin
			blue_coarse_q <= RST_BLUE_COARSE;
			red_fine_q <= RST_FINE;
			green_fine_q <= RST_FINE;
			blue_fine_q <= RST_FINE;
			pin_ctrl_q <= RST_PIN_CTRL;
			rdata_q <= 8'h00;
		end else begin
			blue_coarse_q <= blue_coarse_d;
			red_fine_q <= red_fine_d;
			green_fine_q <= green_fine_d;
			blue_fine_q <= blue_fine_d;
			pin_ctrl_q <= pin_ctrl_d;
			rdata_q <= rdata_d;
		end
	end

	// Calibration bytes: reset value is a parameter-free zero,
	// since their contents belong to another block
	genvar g;
	generate
		for (g = 0; g < CAL_COUNT; g++) begin : g_cal
			always_ff @(posedge sys_clk_i) begin
				if (!rst_b_i) begin
					cal_q[g] <= 8'h00;
				end else begin
					cal_q[g] <= cal_d[g];
				end
			end
			assign cal_bytes_o[8*g +: 8] = cal_q[g];
		end
	endgenerate

	//----------------------------------------
	// Outputs
	//----------------------------------------
	// Bit 7 of each byte is its MSB, first on the serial bus
	assign rdata_o = rdata_q;
	// Codes leave as stored; the analog side scales them
	assign blue_gain_code_o = blue_coarse_q[1:0];
	assign red_top_ref_code_o = red_fine_q;
	assign green_top_ref_code_o = green_fine_q;
	assign blue_top_ref_code_o = blue_fine_q;
	// Delay itself is analog; only the code leaves here
	assign readback_clock_delay_o = pin_ctrl_q[6:5];
	// Clock path stays combinational to avoid halving its rate
	assign readback_clock_o = readback_clock_i ^ pin_ctrl_q[POS_INVERT];
	assign gp_out_one_o = pin_ctrl_q[0];
	assign gp_out_two_o = pin_ctrl_q[1];
	assign gp_out_three_o = pin_ctrl_q[2];
endmodule
`default_nettype wire

/* design/cal_gate.sv */
// Calibration access decision and address window check.
// Assumes the test mode strap is already synchronised.
`default_nettype none
module cal_gate
	import gain_regs_pkg::*;
(
	input wire logic [7:0] addr_i, // Register offset
	input wire logic cal_access_i, // Access bit from control
	input wire logic test_mode_i, // Synchronised test strap
	output logic in_cal_o, // Offset is calibration
	output logic cal_open_o // Calibration may be reached
);
	//----------------------------------------
	// Window and gate
	//----------------------------------------
	assign in_cal_o = (addr_i >= OFF_CAL_FIRST) && (addr_i <= OFF_CAL_LAST);
	assign cal_open_o = cal_access_i | test_mode_i;
endmodule
`default_nettype wire

/* design/gain_regs_pkg.sv */
// Constants for the gain, top reference and pin control register bank.
// Assumes a byte-wide register port fed by the serial bus front end.
`default_nettype none
package gain_regs_pkg;
	//----------------------------------------
	// Offsets
	//----------------------------------------
	localparam logic [7:0] OFF_BLUE_COARSE = 8'h33;
	localparam logic [7:0] OFF_RED_FINE = 8'h34;
	localparam logic [7:0] OFF_GREEN_FINE = 8'h35;
	localparam logic [7:0] OFF_BLUE_FINE = 8'h36;
	localparam logic [7:0] OFF_PIN_CTRL = 8'h37;
	localparam logic [7:0] OFF_CAL_FIRST = 8'h38;
	localparam logic [7:0] OFF_CAL_LAST = 8'h3C;
	//----------------------------------------
	// Reset values and field positions
	//----------------------------------------
	localparam logic [7:0] RST_BLUE_COARSE = 8'h20;
	localparam logic [7:0] RST_FINE = 8'h14;
	localparam logic [7:0] RST_PIN_CTRL = 8'hC0;
	localparam int POS_INVERT = 7;
	localparam int POS_CAL_ACCESS = 3;
	localparam int CAL_COUNT = 5;
endpackage
`default_nettype wire

/* tb/gain_regs_props.sv */
// Checker on the bank's ports.
// Bound onto every bank instance; one clock.
`default_nettype none
module gain_regs_chk(
	input wire logic sys_clk_i, rst_b_i, wr_i, rd_i, readback_clock_i,
	input wire logic [7:0] addr_i, wdata_i, rdata_o,
	input wire logic [7:0] red_top_ref_code_o, green_top_ref_code_o,
	input wire logic [1:0] blue_gain_code_o, readback_clock_delay_o,
	input wire logic readback_clock_o, gp_out_one_o, gp_out_two_o,
	input wire logic gp_out_three_o, test_pin_i
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);
	logic w37;
	// Control write, shared by three checks
	assign w37 = wr_i && addr_i == 8'h37;
	property p_inv; w37 |=> readback_clock_o ==
		(readback_clock_i ^ $past(wdata_i[7])); endproperty
	a_inv: assert property (p_inv) else $error("invert");
	property p_dly;
		w37 |=> readback_clock_delay_o == $past(wdata_i[6:5]); endproperty
	a_dly: assert property (p_dly) else $error("delay");
	property p_gp; w37 |=> {gp_out_three_o, gp_out_two_o, gp_out_one_o}
		== $past(wdata_i[2:0]); endproperty
	a_gp: assert property (p_gp) else $error("pins");
	property p_gain; wr_i && addr_i == 8'h33 |=>
		blue_gain_code_o == $past(wdata_i[1:0]); endproperty
	a_gain: assert property (p_gain) else $error("gain");
	property p_fine; wr_i && addr_i == 8'h34 |=>
		red_top_ref_code_o == $past(wdata_i); endproperty
	a_fine: assert property (p_fine) else $error("fine");
	property p_hold; !(wr_i && addr_i == 8'h34) |=>
		$stable(red_top_ref_code_o); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_rd; rd_i && addr_i == 8'h35 |=>
		rdata_o == $past(green_top_ref_code_o); endproperty
	a_rd: assert property (p_rd) else $error("read");
	// Reset values must show even while reset is held
	property p_rst; disable iff (1'b0) !rst_b_i |=> blue_gain_code_o == 2'd0
		&& red_top_ref_code_o == 8'h14 && readback_clock_delay_o == 2'd2;
	endproperty
	a_rst: assert property (p_rst) else $error("reset");
	c_ctl: cover property (w37);
	c_cal: cover property (rd_i && addr_i == 8'h3C);
	c_test: cover property (test_pin_i && wr_i);
endmodule
bind adc_gain_pin_select_regs gain_regs_chk u_chk(.*);
`default_nettype wire

/* tb/host_model.sv */
// Host master: byte writes and reads on the bank port.
// Assumes strobes are taken on the rising edge.
`default_nettype none
module host_model(
	input wire logic clk_i, // Bank clock
	input wire logic [7:0] rdata_i, // Read byte
	output var logic [7:0] addr_o, wdata_o, // Offset and byte
	output var logic wr_o, rd_o // One-cycle strobes
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {addr_o, wdata_o, wr_o, rd_o} = '0;
	// Strobe launched and dropped on falling edges
	task automatic wr(input logic [7:0] a, d);
		@(negedge clk_i);
		{addr_o, wdata_o, wr_o} = {a, d, 1'b1};
		@(negedge clk_i);
		wr_o = 1'b0;
		wdata_o = ~d; // Released bus never holds the old byte
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_i);
		{addr_o, rd_o} = {a, 1'b1};
		@(negedge clk_i);
		rd_o = 1'b0;
		d = rdata_i;
	endtask
endmodule
`default_nettype wire

/* tb/tb_adc_gain_pin_select_regs.sv */
// Bench for the register bank, driven through the host model.
// Assumes one-cycle write and read timing at the bank.
`default_nettype none
module tb_adc_gain_pin_select_regs;
	timeunit 1ns;
	timeprecision 1ns;
	import gain_regs_pkg::*;
	logic clk = 1'b0, rst_b = 1'b0, tp = 1'b0, rbk = 1'b0;
	logic wr, rd, o1, o2, o3, rco;
	logic [7:0] a, d, rdat, rf, gf, bf;
	logic [7:0] fv[3] = '{8'h00, 8'hFF, 8'h80};
	logic [7:0] cv[4] = '{8'h05, 8'hA2, 8'h47, 8'hE0};
	logic [1:0] gain, dly;
	logic [39:0] cal;
	int miscompares = 0, n_checks = 0, cyc = 0;
	adc_gain_pin_select_regs dut_u(.sys_clk_i(clk), .rst_b_i(rst_b),
		.addr_i(a), .wdata_i(d), .wr_i(wr), .rd_i(rd), .test_pin_i(tp),
		.readback_clock_i(rbk), .rdata_o(rdat), .blue_gain_code_o(gain),
		.red_top_ref_code_o(rf), .green_top_ref_code_o(gf),
		.blue_top_ref_code_o(bf), .readback_clock_delay_o(dly),
		.readback_clock_o(rco), .gp_out_one_o(o1), .gp_out_two_o(o2),
		.gp_out_three_o(o3), .cal_bytes_o(cal));
	host_model u_host(.clk_i(clk), .rdata_i(rdat), .addr_o(a), .wdata_o(d),
		.wr_o(wr), .rd_o(rd));
	initial forever #25 clk = ~clk;
	always @(negedge clk) rbk <= ~rbk;
	// Hang guard: run needs about 70 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			complete_run();
		end
	end
	task automatic chk(string n, logic [7:0] s, e);
		n_checks++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rchk(logic [7:0] ad, e);
		logic [7:0] r;
		u_host.rd(ad, r);
		chk("rdata", r, e);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		rchk(OFF_BLUE_COARSE, 8'h20);
		rchk(OFF_PIN_CTRL, 8'hC0);
		chk("clk", rco ^ rbk, 8'h01);
		for (int g = 0; g < 4; g++) begin
			u_host.wr(OFF_BLUE_COARSE, {6'h08, 2'(g)});
			chk("gain", gain, 8'(g));
		end
		foreach (fv[i]) rchk(8'(OFF_RED_FINE + i), 8'h14);
		foreach (fv[i]) u_host.wr(8'(OFF_RED_FINE + i), fv[i]);
		foreach (fv[i]) rchk(8'(OFF_RED_FINE + i), fv[i]);
		chk("blue", bf, fv[2]);
		chk("red", rf, fv[0]);
		chk("green", gf, fv[1]);
		foreach (cv[i]) begin
			u_host.wr(OFF_PIN_CTRL, cv[i]);
			chk("delay", dly, 8'(cv[i][6:5]));
			chk("gp", {o3, o2, o1}, 8'(cv[i][2:0]));
			chk("clk", rco ^ rbk, 8'(cv[i][7]));
		end
		u_host.wr(OFF_CAL_FIRST, 8'h5A);
		rchk(OFF_CAL_FIRST, 8'h00);
		chk("cal38", cal[7:0], 8'h00);
		u_host.wr(OFF_PIN_CTRL, 8'hC8);
		u_host.wr(OFF_CAL_LAST, 8'h5A);
		rchk(OFF_CAL_LAST, 8'h5A);
		chk("cal3c", cal[39:32], 8'h5A);
		u_host.wr(OFF_PIN_CTRL, 8'hC0);
		rchk(OFF_CAL_LAST, 8'h00);
		tp = 1'b1;
		repeat (2) @(negedge clk);
		u_host.wr(8'h39, 8'hC3);
		chk("cal", cal[15:8], 8'hC3);
		rchk(8'h39, 8'hC3);
		complete_run();
	end
endmodule
`default_nettype wire
